// ### verilog/i2cic_top.sv
// Overview of operation
// R1: buffer flags raise nothing while buffer enable clear
// R2: buffer and event enables route buffer flags
// R3: event enable gates every event interrupt
// R4: start, address, header, stop flags are events
// R5: byte done raises event without buffer flags
// R6: error enable gates the five error flags
// R7: software programs bus clock MHz into setting
// R8: settings 2..48 valid, others disable timing
// R9: bit 15 selects 7 or 10 bit address
// R10: 7-bit uses bits 7:1, 10-bit uses 9:0
// R11: software keeps bit 14 of address one
// R12: dual enable adds the second own address
// R13: second address bits 7:1, compared when dual
// R14: dual addressing ignored in 10-bit mode
// R15: software rewrites reserved fields with reset value
// R16: checksum mismatch forces not-acknowledge
// R17: interrupt lines are OR of enabled flags
`include "i2cic_defs.svh"
`default_nettype none
module i2cic_top
  import i2cic_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // peripheral bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status flags from the status logic
  input wire i2cic_flags_s flags,
  input wire logic ack_enable,
  // serial link pins, sampled
  input wire logic scl_in,
  input wire logic sda_in,
  // results
  output logic event_irq,
  output logic error_irq,
  output logic [5:0] pclk_mhz_setting,
  output logic timing_enable,
  output logic ack_allow,
  output logic addr_match,
  output logic match_second
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic buffer_irq_enable;
  logic event_irq_enable;
  logic error_irq_enable;
  logic ten_bit_select;
  logic keep_one;
  logic [9:0] own_addr;
  logic [6:0] second_own_addr;
  logic two_address_enable;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  logic wr_access;
  logic rd_setup;
  logic mapped;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = hit(paddr, `I2CIC_OFF_IRQCLK) ||
                  hit(paddr, `I2CIC_OFF_OADDR1) ||
                  hit(paddr, `I2CIC_OFF_OADDR2);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buffer_irq_enable <= 1'(`I2CIC_RST_IRQCLK >> `I2CIC_BUF_EN_BIT);
      event_irq_enable <= 1'b0;
      error_irq_enable <= 1'b0;
      pclk_mhz_setting <= 6'h00;
    end else if (wr_access && hit(paddr, `I2CIC_OFF_IRQCLK)) begin
      buffer_irq_enable <= pwdata[`I2CIC_BUF_EN_BIT];
      event_irq_enable <= pwdata[`I2CIC_EVT_EN_BIT];
      error_irq_enable <= pwdata[`I2CIC_ERR_EN_BIT];
      pclk_mhz_setting <= pwdata[`I2CIC_FREQ_MSB:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ten_bit_select <= 1'b0;
      keep_one <= 1'b0;
      own_addr <= 10'h000;
    end else if (wr_access && hit(paddr, `I2CIC_OFF_OADDR1)) begin
      ten_bit_select <= pwdata[`I2CIC_TEN_BIT_SEL];
      keep_one <= pwdata[`I2CIC_KEEP_ONE_BIT];
      own_addr <= pwdata[9:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      second_own_addr <= 7'h00;
      two_address_enable <= 1'b0;
    end else if (wr_access && hit(paddr, `I2CIC_OFF_OADDR2)) begin
      second_own_addr <= pwdata[7:1];
      two_address_enable <= pwdata[`I2CIC_DUAL_EN_BIT];
    end
  end
  // read data captured in the setup phase, reserved bits zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (hit(paddr, `I2CIC_OFF_IRQCLK)) begin
        prdata <= {21'h0_0000, buffer_irq_enable, event_irq_enable,
                   error_irq_enable, 2'h0, pclk_mhz_setting};
      end else if (hit(paddr, `I2CIC_OFF_OADDR1)) begin
        prdata <= {16'h0000, ten_bit_select, keep_one, 4'h0, own_addr};
      end else if (hit(paddr, `I2CIC_OFF_OADDR2)) begin
        prdata <= {24'h000000, second_own_addr, two_address_enable};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
  // ----------------------------------------------------------------
  // interrupt combining
  // ----------------------------------------------------------------
  logic buf_src;
  logic evt_src;
  logic err_src;
  assign buf_src = flags.tx_buffer_empty || flags.rx_buffer_full;
  assign evt_src = flags.start_sent_flag || flags.addr_matched_flag ||
                   flags.ten_bit_header_flag || flags.stop_seen_flag || // see R4
                   (flags.byte_done_flag && !buf_src) || // see R5
                   (buffer_irq_enable && buf_src); // see R1 see R2
  assign err_src = flags.bus_fault_flag || flags.arbitration_lost_flag ||
                   flags.ack_missing_flag || flags.overrun_flag ||
                   flags.pec_mismatch_flag;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_irq <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      event_irq <= event_irq_enable && evt_src; // see R3 see R17
      error_irq <= error_irq_enable && err_src; // see R6 see R17
    end
  end
  // clock setting check and forced not-acknowledge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timing_enable <= 1'b0;
    end else begin
      timing_enable <= (pclk_mhz_setting >= `I2CIC_FREQ_MIN) &&
                       (pclk_mhz_setting <= `I2CIC_FREQ_MAX); // see R8
    end
  end
  assign ack_allow = ack_enable && !flags.pec_mismatch_flag; // see R16
  // ----------------------------------------------------------------
  // link sampling and own address compare
  // ----------------------------------------------------------------
  logic [2:0] scl_pipe;
  logic [2:0] sda_pipe;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {scl_pipe, sda_pipe} <= 6'h3F;
    end else begin
      scl_pipe <= {scl_pipe[1:0], scl_in};
      sda_pipe <= {sda_pipe[1:0], sda_in};
    end
  end
  logic scl_rise;
  logic start_seen;
  logic stop_seen;
  assign scl_rise = scl_pipe[1] && !scl_pipe[2];
  assign start_seen = scl_pipe[1] && scl_pipe[2] &&
                      sda_pipe[2] && !sda_pipe[1];
  assign stop_seen = scl_pipe[1] && scl_pipe[2] &&
                     !sda_pipe[2] && sda_pipe[1];
  i2cic_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_byte;
  logic byte_end;
  logic first_hit;
  logic second_hit;
  logic header_hit;
  logic low_hit;
  assign next_byte = {shreg[6:0], sda_pipe[1]};
  assign byte_end = scl_rise && (bit_cnt == `I2CIC_DATA_BITS - 4'h1);
  assign first_hit = !ten_bit_select &&
                     (next_byte[7:1] == own_addr[7:1]); // see R9 see R10
  assign second_hit = !ten_bit_select && two_address_enable &&
                      (next_byte[7:1] == second_own_addr); // see R12 R13 R14
  assign header_hit = ten_bit_select &&
                      (next_byte[7:1] == {`I2CIC_HDR10, own_addr[9:8]});
  assign low_hit = next_byte == own_addr[7:0]; // see R10
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
    end else if (start_seen || state == I2CIC_IDLE) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
    end else if (scl_rise) begin
      shreg <= next_byte;
      bit_cnt <= (bit_cnt == `I2CIC_SLOT_BITS - 4'h1) ? 4'h0 :
                 bit_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= I2CIC_IDLE;
    end else if (start_seen) begin
      state <= I2CIC_FIRST;
    end else if (stop_seen) begin
      state <= I2CIC_IDLE;
    end else if (byte_end) begin
      case (state)
        I2CIC_FIRST: state <= header_hit ? I2CIC_SECOND : I2CIC_HOLD;
        I2CIC_SECOND: state <= I2CIC_HOLD;
        I2CIC_HOLD: state <= I2CIC_HOLD;
        default: state <= I2CIC_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_match <= 1'b0;
      match_second <= 1'b0;
    end else begin
      addr_match <= byte_end && !start_seen && !stop_seen &&
                    ((state == I2CIC_FIRST && (first_hit || second_hit)) ||
                     (state == I2CIC_SECOND && low_hit));
      match_second <= byte_end && state == I2CIC_FIRST &&
                      !first_hit && second_hit;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_buf_gate;
    @(posedge clk) disable iff (sys_rst)
    (!buffer_irq_enable && !flags.start_sent_flag &&
     !flags.addr_matched_flag && !flags.ten_bit_header_flag &&
     !flags.stop_seen_flag && !(flags.byte_done_flag &&
     !flags.tx_buffer_empty && !flags.rx_buffer_full)) |=> !event_irq;
  endproperty
  a_buf_gate: assert property (p_buf_gate) // see R1
    else $error("buffer flag raised event irq while disabled");
  property p_buf_route;
    @(posedge clk) disable iff (sys_rst)
    (buffer_irq_enable && event_irq_enable && flags.rx_buffer_full)
      |=> event_irq;
  endproperty
  a_buf_route: assert property (p_buf_route) // see R2
    else $error("receive flag did not raise event irq");
  property p_evt_off;
    @(posedge clk) disable iff (sys_rst)
    !event_irq_enable |=> !event_irq;
  endproperty
  a_evt_off: assert property (p_evt_off) // see R3
    else $error("event irq while event enable clear");
  property p_evt_src;
    @(posedge clk) disable iff (sys_rst)
    (event_irq_enable && flags.stop_seen_flag) |=> event_irq;
  endproperty
  a_evt_src: assert property (p_evt_src) // see R4
    else $error("stop flag did not raise event irq");
  property p_byte_done;
    @(posedge clk) disable iff (sys_rst)
    (event_irq_enable && flags.byte_done_flag && !flags.tx_buffer_empty &&
     !flags.rx_buffer_full) |=> event_irq;
  endproperty
  a_byte_done: assert property (p_byte_done) // see R5
    else $error("byte done did not raise event irq");
  property p_err;
    @(posedge clk) disable iff (sys_rst)
    (error_irq_enable && flags.overrun_flag) |=> error_irq;
  endproperty
  a_err: assert property (p_err) // see R6
    else $error("overrun did not raise error irq");
  property p_freq;
    @(posedge clk) disable iff (sys_rst)
    (pclk_mhz_setting == 6'h31) |=> !timing_enable;
  endproperty
  a_freq: assert property (p_freq) // see R8
    else $error("timing enabled for invalid setting");
  property p_nack;
    @(posedge clk) disable iff (sys_rst)
    flags.pec_mismatch_flag |-> !ack_allow;
  endproperty
  a_nack: assert property (p_nack) // see R16
    else $error("acknowledge allowed on checksum mismatch");
  property p_dual10;
    @(posedge clk) disable iff (sys_rst)
    match_second |-> $past(two_address_enable) && !$past(ten_bit_select);
  endproperty
  a_dual10: assert property (p_dual10) // see R12 see R14
    else $error("second address matched while not allowed");
endmodule // i2cic_top
`default_nettype wire

// ### verilog/i2cic_defs.svh
`ifndef I2CIC_DEFS_SVH
`define I2CIC_DEFS_SVH
// register offsets
`define I2CIC_OFF_IRQCLK 8'h04
`define I2CIC_OFF_OADDR1 8'h08
`define I2CIC_OFF_OADDR2 8'h0C
// irq_and_clock_control fields
`define I2CIC_BUF_EN_BIT 10
`define I2CIC_EVT_EN_BIT 9
`define I2CIC_ERR_EN_BIT 8
`define I2CIC_FREQ_MSB 5
// primary_own_address fields
`define I2CIC_TEN_BIT_SEL 15
`define I2CIC_KEEP_ONE_BIT 14
// secondary_own_address fields
`define I2CIC_DUAL_EN_BIT 0
// reset values
`define I2CIC_RST_IRQCLK 16'h0000
`define I2CIC_RST_OADDR1 16'h0000
`define I2CIC_RST_OADDR2 16'h0000
// legal clock frequency setting range, MHz
`define I2CIC_FREQ_MIN 6'h02
`define I2CIC_FREQ_MAX 6'h30
// 10-bit header prefix
`define I2CIC_HDR10 5'h1E
// bits per byte on the link, with the acknowledge slot
`define I2CIC_DATA_BITS 4'h8
`define I2CIC_SLOT_BITS 4'h9
`endif

// ### verilog/i2cic_pkg.sv
`default_nettype none
package i2cic_pkg;
  // status flags raised by the status logic
  typedef struct packed {
    logic tx_buffer_empty;
    logic rx_buffer_full;
    logic start_sent_flag;
    logic addr_matched_flag;
    logic ten_bit_header_flag;
    logic stop_seen_flag;
    logic byte_done_flag;
    logic bus_fault_flag;
    logic arbitration_lost_flag;
    logic ack_missing_flag;
    logic overrun_flag;
    logic pec_mismatch_flag;
  } i2cic_flags_s;

  // address phase tracker
  typedef enum logic [1:0] {
    I2CIC_IDLE = 2'b00,
    I2CIC_FIRST = 2'b01,
    I2CIC_SECOND = 2'b11,
    I2CIC_HOLD = 2'b10
  } i2cic_state_e;
endpackage : i2cic_pkg
`default_nettype wire

// ### bench/i2cic_link_host.sv
`default_nettype none
module i2cic_link_host (
  // serial link, idle high by pull-up
  output var logic scl,
  output var logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic open_frame();
    sda = 1'b0;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  task automatic put_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      // ack slot: line released to the pull-up
      sda = (i == 0) ? 1'b1 : b[i-1];
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
    end
  endtask
  task automatic close_frame();
    sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
    #(2*Q);
  endtask
endmodule // i2cic_link_host
`default_nettype wire

// ### bench/i2cic_irq_and_own_address_config_tb_top.sv
`default_nettype none
module i2c_irq_and_own_address_config_tb_top import i2cic_pkg::*;;
  timeunit 1ns;
  timeprecision 10ps;
  logic clk = 1'b0, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  i2cic_flags_s flags;
  logic ack_enable, scl, sda, event_irq, error_irq, timing_enable;
  logic ack_allow, addr_match, match_second, ee, er;
  logic [5:0] pclk_mhz_setting;
  logic [11:0] v;
  int errors = 0, n_checks = 0, cyc = 0, n_hit, n_sec;
  int fv[7] = '{0, 1, 2, 3, 48, 49, 63};
  i2cic_top i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
    .ack_enable(ack_enable), .scl_in(scl), .sda_in(sda),
    .event_irq(event_irq), .error_irq(error_irq),
    .pclk_mhz_setting(pclk_mhz_setting), .timing_enable(timing_enable),
    .ack_allow(ack_allow), .addr_match(addr_match),
    .match_second(match_second));
  i2cic_link_host i_host (.scl(scl), .sda(sda));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (addr_match === 1'b1) n_hit <= n_hit + 1;
    if (match_second === 1'b1) n_sec <= n_sec + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  // ----------------
  // checks and bus
  // ----------------
  task chk_val(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task chk_bit(input logic got, exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 {psel, pwrite, paddr, pwdata} = {2'b11, a, d};
    @(posedge clk);
    #1 penable = 1'b1;
    @(posedge clk);
    #1 {psel, penable, pwrite} = 3'h0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp,
             input logic eerr, input string what);
    logic [31:0] d;
    logic e;
    logic r;
    @(posedge clk);
    #1 {psel, pwrite, paddr} = {2'b10, a};
    @(posedge clk);
    #1 penable = 1'b1;
    @(posedge clk);
    d = prdata;
    e = pslverr;
    r = pready;
    #1 {psel, penable} = 2'h0;
    chk_val(d, exp, what);
    chk_bit(e, eerr, what);
    chk_bit(r, 1'b1, what);
  endtask
  task frame(input logic [7:0] b0, b1, input bit two,
             input int hits, secs, input string what);
    n_hit = 0;
    n_sec = 0;
    i_host.open_frame();
    i_host.put_byte(b0);
    if (two) i_host.put_byte(b1);
    i_host.close_frame();
    repeat (10) @(posedge clk);
    chk_val(n_hit, hits, what);
    chk_val(n_sec, secs, what);
  endtask
  task test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
    flags = i2cic_flags_s'(12'h000);
    ack_enable = 1'b0;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    rdchk(8'h04, 32'h0, 1'b0, "ctrl reset");
    rdchk(8'h08, 32'h0, 1'b0, "oaddr1 reset");
    rdchk(8'h0C, 32'h0, 1'b0, "oaddr2 reset");
    rdchk(8'h10, 32'h0, 1'b1, "unmapped");
    $display("test reset done");
    foreach (fv[k]) begin
      wr(8'h04, 32'(fv[k]));
      repeat (2) @(posedge clk);
      #1 chk_bit(timing_enable, fv[k] >= 2 && fv[k] <= 48, "timing");
      chk_val(32'(pclk_mhz_setting), fv[k], "freq field");
    end
    $display("test frequency done");
    for (int en = 0; en < 8; en++) begin
      wr(8'h04, {21'h0, en[2:0], 8'h08});
      rdchk(8'h04, {21'h0, en[2:0], 8'h08}, 1'b0, "ctrl rb");
      for (int i = 0; i < 13; i++) begin
        v = (i == 12) ? 12'h820 : 12'h800 >> i;
        flags = i2cic_flags_s'(v);
        ack_enable = en[1];
        ee = en[1] & (|v[9:6] | v[5] & ~|v[11:10] | en[2] & |v[11:10]);
        er = en[0] & |v[4:0];
        @(posedge clk);
        #1 chk_bit(event_irq, ee, "event irq");
        chk_bit(error_irq, er, "error irq");
        chk_bit(ack_allow, en[1] & ~v[0], "ack allow");
      end
    end
    flags = i2cic_flags_s'(12'h000);
    $display("test interrupts done");
    wr(8'h08, 32'h435B);
    frame(8'h5A, 8'h00, 0, 1, 0, "own 7-bit");
    frame(8'h5C, 8'h00, 0, 0, 0, "other 7-bit");
    wr(8'h0C, 32'h0067);
    frame(8'h67, 8'h00, 0, 1, 1, "second");
    frame(8'h5B, 8'h00, 0, 1, 0, "first dual");
    wr(8'h0C, 32'h0066);
    frame(8'h67, 8'h00, 0, 0, 0, "dual off");
    wr(8'h0C, 32'h0067);
    wr(8'h08, 32'hC2B5);
    frame(8'hF4, 8'hB5, 1, 1, 0, "ten bit");
    frame(8'hF4, 8'hB4, 1, 0, 0, "ten miss");
    frame(8'h67, 8'h00, 0, 0, 0, "dual in ten");
    rdchk(8'h08, 32'hC2B5, 1'b0, "oaddr1 rb");
    rdchk(8'h0C, 32'h0067, 1'b0, "oaddr2 rb");
    $display("test addresses done");
    test_done();
  end
endmodule // i2c_irq_and_own_address_config_tb_top
`default_nettype wire
